// ### design/spsr_top.v
// 8-stage shift register with synchronous parallel load and serial shift,
// plus its command FIFO. Assumes one clock, inputs synchronous to ref_clk.
//
// Contract
// - Eight stages in series, one serial input, parallel input per stage.
// - Stages are edge-triggered; outputs change only at a rising clock edge. The code also resets them at once when nrst falls.
// - Only stages six, seven, eight are driven out; eighth is serial out.
// - Load and shift happen only at the rising edge, chosen by select.
// - Select high at the edge copies all eight parallel inputs at once.
// - Select low: serial input enters stage one, others take predecessor.
`timescale 1ns/1ps
`include "spsr_consts.vh"

// ----------------------------------------
// Command FIFO
// ----------------------------------------
module spsr_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire ref_clk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam [AW:0] COUNT_ONE = {{AW{1'h0}}, 1'h1};
    localparam [AW-1:0] PTR_ONE = {{(AW-1){1'h0}}, 1'h1};
    localparam [AW:0] COUNT_FULL = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    reg ready_reg;
    wire push;
    wire pop;

    // Ready is a flop fed by the next count, so the writer never sees a gated full flag
    assign in_ready = ready_reg;
    assign out_valid = (count_reg != {(AW+1){1'h0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && ready_reg;
    assign pop = out_valid && out_ready;

    always @* begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + COUNT_ONE;
        end else if (pop && !push) begin
            count_next = count_reg - COUNT_ONE;
        end
    end

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= {AW{1'h0}};
            rd_ptr_reg <= {AW{1'h0}};
            count_reg <= {(AW+1){1'h0}};
            ready_reg <= 1'h1;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            end
            count_reg <= count_next;
            ready_reg <= (count_next != COUNT_FULL);
        end
    end
endmodule

// ----------------------------------------
// One storage stage
// ----------------------------------------
// The device has no reset pin; the reset value only gives a known start
module spsr_stage #(
    parameter RESET_BIT = 1'h0
) (
    input wire ref_clk,
    input wire nrst,
    input wire step,
    input wire load,
    input wire par_bit,
    input wire prev_bit,
    output reg q_reg,
    output reg q_next
);
    always @* begin
        q_next = q_reg;
        if (step) begin
            if (load) begin
                q_next = par_bit;
            end else begin
                q_next = prev_bit;
            end
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= RESET_BIT;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule

// ----------------------------------------
// Shift register top
// ----------------------------------------
module spsr_top (
    input wire ref_clk,
    input wire nrst,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire load_sel,
    input wire [7:0] par_in,
    input wire ser_in,
    input wire drain_ready,
    output reg stage6_q,
    output reg stage7_q,
    output reg stage8_q
);
    localparam [7:0] RESET_VAL = `SPSR_RESET_VAL;

    wire [`SPSR_FIFO_WIDTH-1:0] fifo_in;
    wire [`SPSR_FIFO_WIDTH-1:0] fifo_out;
    wire fifo_valid;
    wire step;
    wire load;
    wire ser_bit;
    wire [6:0] stage_q;
    wire [7:0] stage_next;

    // Serial bit rides in the parallel field when select is low
    assign fifo_in = {load_sel, load_sel ? par_in : {7'h00, ser_in}};

    spsr_fifo #(
        .WIDTH(`SPSR_FIFO_WIDTH),
        .DEPTH(`SPSR_FIFO_DEPTH),
        .AW(`SPSR_FIFO_AW)
    ) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(drain_ready),
        .out_data(fifo_out)
    );

    // One queued command is one clock of the register
    assign step = fifo_valid && drain_ready;
    assign load = fifo_out[`SPSR_CMD_SEL_BIT];
    assign ser_bit = fifo_out[`SPSR_CMD_PAR_LO];

    // ----------------------------------------
    // Eight stages in series; index 0 is the first stage
    // ----------------------------------------
    spsr_stage #(
        .RESET_BIT(RESET_VAL[0])
    ) u_stage1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[0]),
        .prev_bit(ser_bit),
        .q_reg(stage_q[0]),
        .q_next(stage_next[0])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[1])
    ) u_stage2 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[1]),
        .prev_bit(stage_q[0]),
        .q_reg(stage_q[1]),
        .q_next(stage_next[1])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[2])
    ) u_stage3 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[2]),
        .prev_bit(stage_q[1]),
        .q_reg(stage_q[2]),
        .q_next(stage_next[2])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[3])
    ) u_stage4 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[3]),
        .prev_bit(stage_q[2]),
        .q_reg(stage_q[3]),
        .q_next(stage_next[3])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[4])
    ) u_stage5 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[4]),
        .prev_bit(stage_q[3]),
        .q_reg(stage_q[4]),
        .q_next(stage_next[4])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[5])
    ) u_stage6 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[5]),
        .prev_bit(stage_q[4]),
        .q_reg(stage_q[5]),
        .q_next(stage_next[5])
    );
    spsr_stage #(
        .RESET_BIT(RESET_VAL[6])
    ) u_stage7 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[6]),
        .prev_bit(stage_q[5]),
        .q_reg(stage_q[6]),
        .q_next(stage_next[6])
    );
    // Nothing reads the eighth stage's own flop; the serial pin has its own copy
    spsr_stage #(
        .RESET_BIT(RESET_VAL[7])
    ) u_stage8 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .step(step),
        .load(load),
        .par_bit(fifo_out[7]),
        .prev_bit(stage_q[6]),
        .q_reg(),
        .q_next(stage_next[7])
    );

    // Pins copy the next values, so they move on the same edge as the stages
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage6_q <= RESET_VAL[5];
            stage7_q <= RESET_VAL[6];
            stage8_q <= RESET_VAL[7];
        end else begin
            stage6_q <= stage_next[5];
            stage7_q <= stage_next[6];
            stage8_q <= stage_next[7];
        end
    end
endmodule

// ### dv/spsr_board.sv
// Board model: paces the register steps for the command queue.
// Assumes go is driven by the bench at the falling edge.
`timescale 1ns/1ps
module spsr_board (
    input wire go,
    output wire drain_ready
);
    assign drain_ready = go;
endmodule

// ### dv/spsr_top_properties.sv
// Checker on the spsr_top ports.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module spsr_top_properties (
    input wire ref_clk,
    input wire nrst,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire load_sel,
    input wire [7:0] par_in,
    input wire drain_ready,
    input wire stage6_q,
    input wire stage7_q,
    input wire stage8_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_hold;
        !$past(drain_ready) |-> $stable({stage6_q, stage7_q, stage8_q});
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while stalled");
    property p_drained;
        (drain_ready && !cmd_valid) [*5] |=> $stable({stage6_q, stage7_q, stage8_q});
    endproperty
    a_drained: assert property (p_drained) else $error("output moved with no queued command");
    property p_full;
        !cmd_ready && !drain_ready |=> !cmd_ready;
    endproperty
    a_full: assert property (p_full) else $error("full queue changed while stalled");
    // Queue occupancy rebuilt from the two handshakes, so checks can see an empty queue
    reg [2:0] occ_reg;
    wire occ_push;
    wire occ_pop;
    assign occ_push = cmd_valid && cmd_ready;
    assign occ_pop = (occ_reg != 3'h0) && drain_ready;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            occ_reg <= 3'h0;
        end else if (occ_push && !occ_pop) begin
            occ_reg <= occ_reg + 3'h1;
        end else if (occ_pop && !occ_push) begin
            occ_reg <= occ_reg - 3'h1;
        end
    end
    property p_ready;
        cmd_ready == (occ_reg != 3'h4);
    endproperty
    a_ready: assert property (p_ready) else $error("ready does not follow queue room");
    property p_empty_hold;
        (occ_reg == 3'h0) |=> $stable({stage6_q, stage7_q, stage8_q});
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("outputs moved with an empty queue");
    property p_load;
        (occ_reg == 3'h0 && cmd_valid && load_sel) ##1 drain_ready
            |=> {stage8_q, stage7_q, stage6_q} == $past(par_in[7:5], 2);
    endproperty
    a_load: assert property (p_load) else $error("load did not copy the parallel bits");
    property p_shift;
        (occ_reg == 3'h0 && cmd_valid && !load_sel) ##1 drain_ready
            |=> (stage8_q == $past(stage7_q)) && (stage7_q == $past(stage6_q));
    endproperty
    a_shift: assert property (p_shift) else $error("shift did not move toward the eighth stage");
    cover property (!cmd_ready);
    cover property (cmd_valid && !drain_ready);
    cover property (drain_ready && cmd_valid);
endmodule

// ### dv/spsr_top_tb.sv
// Bench for spsr_top: random loads and shifts, then a stalled full queue.
// Assumes the board model passes go to drain_ready.
`timescale 1ns/1ps
module spsr_top_tb;
    reg ref_clk = 0, nrst = 0, cmd_valid = 0, load_sel = 0, ser_in = 0, go = 1;
    reg [7:0] par_in = 8'h00, m = 8'h00;
    reg [2:0] x;
    reg [31:0] r;
    wire cmd_ready, drain_ready, s6, s7, s8;
    integer miscompares = 0, checked = 0, i;
    always #2.5 ref_clk = ~ref_clk;
    spsr_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .load_sel(load_sel), .par_in(par_in), .ser_in(ser_in), .drain_ready(drain_ready),
        .stage6_q(s6), .stage7_q(s7), .stage8_q(s8));
    spsr_board brd_u (.go(go), .drain_ready(drain_ready));
    task cmp(input [3:0] seen, input [3:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // Next register image for one command word: bit 8 selects load, bit 9 is the serial bit
    function [7:0] next_image(input [7:0] cur, input [31:0] w);
        begin
            next_image = w[8] ? w[7:0] : {cur[6:0], w[9]};
        end
    endfunction
    // Model moves at push time; the queue delays the ports, not the order
    task push(input [31:0] w);
        begin
            @(negedge ref_clk);
            cmd_valid = 1;
            load_sel = w[8];
            par_in = w[7:0];
            ser_in = w[9];
            @(negedge ref_clk);
            cmd_valid = 0;
            m = next_image(m, w);
        end
    endtask
    task end_of_test;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        r = $urandom(32'hEE9C0377);
        repeat (3) @(negedge ref_clk);
        nrst = 1;
        push(32'h0000_01A5);
        @(negedge ref_clk);
        cmp({cmd_ready, s8, s7, s6}, 4'hD);
        push(32'h0000_0300);
        @(negedge ref_clk);
        cmp({cmd_ready, s8, s7, s6}, 4'h8);
        for (i = 0; i < 8; i = i + 1) begin
            push(32'h0000_02FF);
            @(negedge ref_clk);
            cmp({cmd_ready, s8, s7, s6}, {1'b1, m[7:5]});
        end
        cmp({cmd_ready, s8, s7, s6}, 4'hF);
        $display("corner load and shift done");
        for (i = 0; i < 40; i = i + 1) begin
            push($urandom);
            @(negedge ref_clk);
            cmp({cmd_ready, s8, s7, s6}, {1'b1, m[7:5]});
        end
        $display("random load and shift done");
        go = 0;
        x = m[7:5];
        for (i = 0; i < 4; i = i + 1) push($urandom);
        cmp({cmd_ready, s8, s7, s6}, {1'b0, x});
        go = 1;
        repeat (6) @(negedge ref_clk);
        cmp({cmd_ready, s8, s7, s6}, {1'b1, m[7:5]});
        $display("stalled queue done");
        end_of_test;
    end
    // About 170 cycles are expected; this allows roughly six times that
    initial begin
        #5000;
        miscompares = miscompares + 1;
        end_of_test;
    end
endmodule
bind spsr_top spsr_top_properties chk_u (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .load_sel(load_sel), .par_in(par_in), .drain_ready(drain_ready),
    .stage6_q(stage6_q), .stage7_q(stage7_q), .stage8_q(stage8_q));

// ### inc/spsr_consts.vh
// Constants for the 8-stage parallel-in / serial-out shift register.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SPSR_CONSTS_VH
`define SPSR_CONSTS_VH

// ----------------------------------------
// Structure
// ----------------------------------------
`define SPSR_STAGES 8
`define SPSR_RESET_VAL 8'h00
`define SPSR_FIFO_WIDTH 9
`define SPSR_FIFO_DEPTH 4
`define SPSR_FIFO_AW 2

// ----------------------------------------
// Field positions of a queued command word
// ----------------------------------------
`define SPSR_CMD_SEL_BIT 8
`define SPSR_CMD_PAR_HI 7
`define SPSR_CMD_PAR_LO 0

`endif
